// ===== verilog/dfvp_top.v
// Implementation choices: the plain strobed port and the register offsets.
`timescale 1ns/100ps
`include "dfvp_regs.vh"

module dfvp_top #(
  parameter TICK_CYC = `DFVP_TICK_CYC
) (
  input  wire        ref_clk,
  input  wire        rst_n,
  input  wire [7:0]  reg_addr,
  input  wire [31:0] reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output reg  [31:0] reg_rdata,
  input  wire        run_cmd,
  input  wire        dir_reverse,
  input  wire        dc_brake_input,
  input  wire [15:0] output_current,
  input  wire [15:0] main_input_volt,
  output reg  [15:0] out_freq_q,
  output reg  [15:0] volt_cmd_q,
  output reg  [15:0] dc_current_q,
  output reg         dc_inject_q,
  output reg         gate_enable_q,
  output reg         motor_thermal_trip,
  output reg         multifunction_output_pin
);

  localparam [5:0] ST_IDLE  = 6'h01;
  localparam [5:0] ST_SBRK  = 6'h02;
  localparam [5:0] ST_RUN   = 6'h04;
  localparam [5:0] ST_BLOCK = 6'h08;
  localparam [5:0] ST_DCBRK = 6'h10;
  localparam [5:0] ST_TRIP  = 6'h20;

  function [15:0] min16;
    input [15:0] a;
    input [15:0] b;
    begin
      min16 = (a < b) ? a : b;
    end
  endfunction

  // Guards the dividers by rated current and base frequency against a zero setting
  function [15:0] nz16;
    input [15:0] a;
    begin
      nz16 = (a == 16'h0000) ? 16'h0001 : a;
    end
  endfunction

  function integer interp;
    input integer f;
    input integer fa;
    input integer va;
    input integer fb;
    input integer vb;
    begin
      if (fb <= fa || f >= fb)
        interp = vb;
      else if (f <= fa)
        interp = va;
      else
        interp = va + ((f - fa) * (vb - va)) / (fb - fa);
    end
  endfunction

  function [31:0] rst_word;
    input [3:0] idx;
    begin
      case (idx)
        4'h0:    rst_word = `DFVP_RST_CTRL;
        4'h1:    rst_word = `DFVP_RST_STOPFREQ;
        4'h2:    rst_word = `DFVP_RST_STOPBRK;
        4'h3:    rst_word = `DFVP_RST_STARTBRK;
        4'h4:    rst_word = `DFVP_RST_FREQLIM;
        4'h5:    rst_word = `DFVP_RST_STARTLOW;
        4'h6:    rst_word = `DFVP_RST_HIGHREF;
        4'h7:    rst_word = `DFVP_RST_BOOST;
        4'h8:    rst_word = `DFVP_RST_VOLTADJ;
        4'h9:    rst_word = `DFVP_RST_THERMAL;
        4'ha:    rst_word = `DFVP_RST_WARN;
        4'hb:    rst_word = `DFVP_RST_RATED;
        default: rst_word = 32'h0000_0000;
      endcase
    end
  endfunction

  reg  [31:0] cfg_q [0:`DFVP_NUM_CFG-1];
  reg  [2:0]  pin_m_q;
  reg  [2:0]  pin_s_q;
  reg  [23:0] tick_cnt_q;
  reg  [5:0]  state_q;
  reg  [15:0] seq_cnt_q;
  reg         steady_q;
  reg  [15:0] ref_prev_q;
  reg  [39:0] heat_q;
  reg  [15:0] over_cnt_q;
  reg  [15:0] hold_cnt_q;
  reg         alarm_q;
  integer     i;

  wire [31:0] ctrl       = cfg_q[0];
  wire        stop_dc    = ctrl[`DFVP_CTRL_STOP_DC];
  wire        limit_en   = ctrl[`DFVP_CTRL_LIMIT_EN];
  wire        auto_boost = ctrl[`DFVP_CTRL_AUTO];
  wire [1:0]  curve      = ctrl[`DFVP_CTRL_CURVE_HI:`DFVP_CTRL_CURVE_LO];
  wire        therm_en   = ctrl[`DFVP_CTRL_THERM_EN];
  wire        forced     = ctrl[`DFVP_CTRL_FORCED];
  wire        mo_ol      = ctrl[`DFVP_CTRL_MO_OL];
  wire        motor2     = ctrl[`DFVP_CTRL_MOTOR2];
  wire [15:0] stop_brake_start_freq = cfg_q[1][15:0];
  wire [15:0] stop_brake_on_delay   = cfg_q[1][31:16];
  wire [15:0] stop_brake_level      = cfg_q[2][15:0];
  wire [15:0] stop_brake_duration   = cfg_q[2][31:16];
  wire [15:0] start_brake_level     = cfg_q[3][15:0];
  wire [15:0] start_brake_duration  = cfg_q[3][31:16];
  wire [15:0] max_output_freq       = cfg_q[4][15:0];
  wire [15:0] base_output_freq      = cfg_q[4][31:16];
  wire [15:0] start_output_freq     = cfg_q[5][15:0];
  wire [15:0] freq_low_limit        = cfg_q[5][31:16];
  wire [15:0] freq_ref              = cfg_q[6][15:0];
  wire [15:0] freq_high_limit       = cfg_q[6][31:16];
  wire [15:0] boost_forward         = cfg_q[7][15:0];
  wire [15:0] boost_reverse         = cfg_q[7][31:16];
  wire [15:0] output_volt_scale     = cfg_q[8][15:0];
  wire [15:0] energy_save_pct       = cfg_q[8][31:16];
  wire [15:0] thermal_one_min_level = cfg_q[9][15:0];
  wire [15:0] thermal_cont_level    = cfg_q[9][31:16];
  wire [15:0] overload_warn_level   = cfg_q[10][15:0];
  wire [15:0] overload_warn_time    = cfg_q[10][31:16];
  wire [15:0] rated_motor_current   = cfg_q[11][15:0];
  wire [15:0] accel_step            = cfg_q[11][31:16];

  wire run_s = pin_s_q[0];
  wire rev_s = pin_s_q[1];
  wire dcb_s = pin_s_q[2];
  wire tick  = (tick_cnt_q == TICK_CYC[23:0] - 24'h000001);
  wire [3:0] widx = reg_addr[5:2];
  wire cfg_hit = (reg_addr[7:6] == 2'b00) && (reg_addr[1:0] == 2'b00);

  // Frequency target
  reg  [15:0] ref_c;
  reg  [15:0] lim_f;
  reg  [15:0] target;
  reg  [15:0] cur_pct;
  reg  [31:0] pct_w;
  always @* begin
    ref_c = min16(freq_ref, max_output_freq);
    lim_f = ref_c;
    if (ref_c > freq_high_limit)
      lim_f = freq_high_limit;
    else if (ref_c < freq_low_limit)
      lim_f = freq_low_limit;
    lim_f = min16(lim_f, max_output_freq);
    // Ramps aim at the reference capped at maximum; the limit clamp joins only once steady
    target = (limit_en && steady_q) ? lim_f : ref_c;
    pct_w = {16'h0000, output_current} * 32'd100 /
            {16'h0000, nz16(rated_motor_current)};
    // Saturates rather than wrapping on a huge overcurrent
    cur_pct = (pct_w > 32'd65535) ? 16'hffff : pct_w[15:0];
  end

  // Voltage pattern, in per mille of rated voltage
  integer f_i, b_i, s_i, lin, curv, boost, v, load;
  always @* begin
    f_i = out_freq_q;
    b_i = nz16(base_output_freq);
    s_i = start_output_freq;
    lin = (f_i >= b_i) ? `DFVP_FULL_PM : (f_i * `DFVP_FULL_PM) / b_i;
    case (curve)
      `DFVP_CURVE_SQUARE: curv = (lin * lin) / `DFVP_FULL_PM;
      `DFVP_CURVE_USER: begin
        // Chain of segments start, four points, base
        if (f_i < cfg_q[12][15:0])
          curv = interp(f_i, s_i, 0, cfg_q[12][15:0], cfg_q[12][31:16]);
        else if (f_i < cfg_q[13][15:0])
          curv = interp(f_i, cfg_q[12][15:0], cfg_q[12][31:16],
                        cfg_q[13][15:0], cfg_q[13][31:16]);
        else if (f_i < cfg_q[14][15:0])
          curv = interp(f_i, cfg_q[13][15:0], cfg_q[13][31:16],
                        cfg_q[14][15:0], cfg_q[14][31:16]);
        else if (f_i < cfg_q[15][15:0])
          curv = interp(f_i, cfg_q[14][15:0], cfg_q[14][31:16],
                        cfg_q[15][15:0], cfg_q[15][31:16]);
        else
          curv = interp(f_i, cfg_q[15][15:0], cfg_q[15][31:16],
                        b_i, `DFVP_FULL_PM);
      end
      default: curv = lin;
    endcase
    boost = rev_s ? boost_reverse : boost_forward;
    load = (output_current * `DFVP_FULL_PM) / nz16(rated_motor_current);
    if (auto_boost && !motor2)
      boost = boost + (load * `DFVP_AUTO_GAIN_PM) / `DFVP_FULL_PM;
    // Boost fades out toward base frequency to avoid flux saturation
    boost = (f_i >= b_i) ? 0 : (boost * (b_i - f_i)) / b_i;
    if (curve == `DFVP_CURVE_USER)
      boost = 0;
    v = ((curv + boost) * output_volt_scale) / 100;
    if (steady_q && out_freq_q == target && energy_save_pct != 16'h0000)
      v = (v * (100 - energy_save_pct)) / 100;
    if (v > main_input_volt)
      v = main_input_volt;
    if (v < 0 || f_i < s_i || state_q != ST_RUN)
      v = 0;
  end

  // Thermal model
  integer cont, heat_in, trip_lvl;
  always @* begin
    cont = thermal_cont_level;
    if (!forced && out_freq_q < base_output_freq)
      cont = (cont * (500 + (500 * f_i) / b_i)) / 1000;
    heat_in = cur_pct * cur_pct - cont * cont;
    trip_lvl = (thermal_one_min_level * thermal_one_min_level -
                thermal_cont_level * thermal_cont_level)
               * `DFVP_MINUTE_TICKS;
  end
  wire therm_trip = therm_en && (trip_lvl > 0) &&
                    (heat_q >= trip_lvl[31:0]);

  // Register bus and input synchronisers
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (i = 0; i < `DFVP_NUM_CFG; i = i + 1)
        cfg_q[i] <= rst_word(i[3:0]);
      reg_rdata <= 32'h0000_0000;
      pin_m_q <= 3'h0;
      pin_s_q <= 3'h0;
    end else begin
      pin_m_q <= {dc_brake_input, dir_reverse, run_cmd};
      pin_s_q <= pin_m_q;
      if (reg_wr && cfg_hit) begin
        if (widx == 4'h4)
          cfg_q[4] <= {min16(reg_wdata[31:16], reg_wdata[15:0]),
                       reg_wdata[15:0]};
        else if (widx == 4'h0)
          cfg_q[0] <= reg_wdata & ~(32'h1 << `DFVP_CTRL_TRIP_CLR);
        else
          cfg_q[widx] <= reg_wdata;
      end
      reg_rdata <= 32'h0000_0000;
      if (reg_rd) begin
        if (cfg_hit)
          reg_rdata <= cfg_q[widx];
        else if (reg_addr == `DFVP_REG_STATUS)
          reg_rdata <= {6'h00, alarm_q, motor_thermal_trip, steady_q,
                        state_q, gate_enable_q, out_freq_q};
        else if (reg_addr == `DFVP_REG_VOLT)
          reg_rdata <= {dc_current_q, volt_cmd_q};
      end
    end
  end

  wire trip_clr = reg_wr && (reg_addr == `DFVP_REG_CTRL) &&
                  reg_wdata[`DFVP_CTRL_TRIP_CLR];

  // Sequencer
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      tick_cnt_q <= 24'h000000;
      state_q <= ST_IDLE;
      seq_cnt_q <= 16'h0000;
      out_freq_q <= 16'h0000;
      steady_q <= 1'b0;
      ref_prev_q <= 16'h0000;
      motor_thermal_trip <= 1'b0;
    end else begin
      tick_cnt_q <= tick ? 24'h000000 : tick_cnt_q + 24'h000001;
      ref_prev_q <= ref_c;
      if (!run_s || ref_c != ref_prev_q || state_q != ST_RUN)
        steady_q <= 1'b0;
      else if (out_freq_q == ref_c)
        steady_q <= 1'b1;
      if (tick)
        seq_cnt_q <= seq_cnt_q + 16'h0001;
      // A trip raised in the clearing cycle stays raised
      motor_thermal_trip <= therm_trip |
                            (motor_thermal_trip & ~trip_clr);
      case (state_q)
        ST_IDLE: begin
          out_freq_q <= 16'h0000;
          seq_cnt_q <= 16'h0000;
          if (run_s && !motor_thermal_trip) begin
            if (start_brake_level != 16'h0000 &&
                start_brake_duration != 16'h0000)
              state_q <= ST_SBRK;
            else
              state_q <= ST_RUN;
            out_freq_q <= start_output_freq;
          end
        end
        ST_SBRK: begin
          if (seq_cnt_q >= start_brake_duration) begin
            state_q <= ST_RUN;
            seq_cnt_q <= 16'h0000;
          end
        end
        ST_RUN: begin
          if (tick) begin
            if (run_s && out_freq_q < target)
              out_freq_q <= (target - out_freq_q > accel_step) ?
                            out_freq_q + accel_step : target;
            else if (run_s && out_freq_q > target)
              out_freq_q <= (out_freq_q - target > accel_step) ?
                            out_freq_q - accel_step : target;
            else if (!run_s)
              out_freq_q <= (out_freq_q > accel_step) ?
                            out_freq_q - accel_step : 16'h0000;
          end
          seq_cnt_q <= 16'h0000;
          if (!run_s && stop_dc &&
              out_freq_q <= stop_brake_start_freq)
            state_q <= ST_BLOCK;
          else if (!run_s && out_freq_q <= start_output_freq) begin
            state_q <= ST_IDLE;
            out_freq_q <= 16'h0000;
          end
        end
        ST_BLOCK: begin
          out_freq_q <= 16'h0000;
          if (seq_cnt_q >= stop_brake_on_delay) begin
            state_q <= ST_DCBRK;
            seq_cnt_q <= 16'h0000;
          end
        end
        ST_DCBRK: begin
          if (seq_cnt_q >= stop_brake_duration)
            state_q <= ST_IDLE;
        end
        ST_TRIP: begin
          out_freq_q <= 16'h0000;
          if (!motor_thermal_trip && !run_s)
            state_q <= ST_IDLE;
        end
        default: state_q <= ST_IDLE;
      endcase
      if (therm_trip)
        state_q <= ST_TRIP;
    end
  end

  // Outputs to the power stage
  reg [15:0] dc_lvl;
  reg [31:0] dc_w;
  always @* begin
    dc_lvl = 16'h0000;
    if (state_q == ST_SBRK || (state_q == ST_IDLE && dcb_s))
      dc_lvl = start_brake_level;
    else if (state_q == ST_DCBRK)
      dc_lvl = stop_brake_level;
    dc_w = {16'h0000, min16(dc_lvl, 16'd1000)} *
           {16'h0000, rated_motor_current} / 32'd1000;
  end

  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      volt_cmd_q <= 16'h0000;
      dc_current_q <= 16'h0000;
      dc_inject_q <= 1'b0;
      gate_enable_q <= 1'b0;
      heat_q <= 40'h00_0000_0000;
      over_cnt_q <= 16'h0000;
      hold_cnt_q <= 16'h0000;
      alarm_q <= 1'b0;
      multifunction_output_pin <= 1'b0;
    end else begin
      volt_cmd_q <= v[15:0];
      // Level is per mille of rated current, never above the rating
      dc_current_q <= min16(dc_w[15:0], rated_motor_current);
      dc_inject_q <= (dc_lvl != 16'h0000) && !motor_thermal_trip;
      gate_enable_q <= (state_q == ST_RUN) && !therm_trip &&
                       (out_freq_q >= start_output_freq);
      if (tick) begin
        if (!therm_en)
          heat_q <= 40'h00_0000_0000;
        else if (heat_in < 0 && heat_q < -heat_in)
          heat_q <= 40'h00_0000_0000;
        else
          heat_q <= heat_q + {{8{heat_in[31]}}, heat_in[31:0]};
        if (cur_pct >= overload_warn_level) begin
          hold_cnt_q <= 16'h0000;
          if (over_cnt_q >= overload_warn_time)
            alarm_q <= 1'b1;
          else
            over_cnt_q <= over_cnt_q + 16'h0001;
        end else begin
          over_cnt_q <= 16'h0000;
          if (hold_cnt_q >= overload_warn_time)
            alarm_q <= 1'b0;
          else
            hold_cnt_q <= hold_cnt_q + 16'h0001;
        end
      end
      // Alarm only signals; it never touches the sequencer
      multifunction_output_pin <= mo_ol & alarm_q;
    end
  end

endmodule // dfvp_top

// ===== verilog/dfvp_regs.vh
`ifndef DFVP_REGS_VH
`define DFVP_REGS_VH

// Byte offsets, each register one aligned 32-bit word
`define DFVP_REG_CTRL       8'h00
`define DFVP_REG_STOPFREQ   8'h04
`define DFVP_REG_STOPBRK    8'h08
`define DFVP_REG_STARTBRK   8'h0c
`define DFVP_REG_FREQLIM    8'h10
`define DFVP_REG_STARTLOW   8'h14
`define DFVP_REG_HIGHREF    8'h18
`define DFVP_REG_BOOST      8'h1c
`define DFVP_REG_VOLTADJ    8'h20
`define DFVP_REG_THERMAL    8'h24
`define DFVP_REG_WARN       8'h28
`define DFVP_REG_RATED      8'h2c
`define DFVP_REG_USER1      8'h30
`define DFVP_REG_USER2      8'h34
`define DFVP_REG_USER3      8'h38
`define DFVP_REG_USER4      8'h3c
`define DFVP_REG_STATUS     8'h40
`define DFVP_REG_VOLT       8'h44
`define DFVP_NUM_CFG        16

// Control word bits
`define DFVP_CTRL_STOP_DC   0
`define DFVP_CTRL_LIMIT_EN  1
`define DFVP_CTRL_AUTO      2
`define DFVP_CTRL_CURVE_LO  3
`define DFVP_CTRL_CURVE_HI  4
`define DFVP_CTRL_THERM_EN  5
`define DFVP_CTRL_FORCED    6
`define DFVP_CTRL_MO_OL     7
`define DFVP_CTRL_TRIP_CLR  8
`define DFVP_CTRL_MOTOR2    9

// Curve codes
`define DFVP_CURVE_LINEAR   2'h0
`define DFVP_CURVE_SQUARE   2'h1
`define DFVP_CURVE_USER     2'h2

// Reset values of the setting words
`define DFVP_RST_CTRL       32'h0000_0020
`define DFVP_RST_STOPFREQ   32'h0001_01f4
`define DFVP_RST_STOPBRK    32'h000a_0032
`define DFVP_RST_STARTBRK   32'h0000_0032
`define DFVP_RST_FREQLIM    32'h1770_1770
`define DFVP_RST_STARTLOW   32'h0000_0032
`define DFVP_RST_HIGHREF    32'h1770_0000
`define DFVP_RST_BOOST      32'h0014_0014
`define DFVP_RST_VOLTADJ    32'h0000_0064
`define DFVP_RST_THERMAL    32'h0064_0096
`define DFVP_RST_WARN       32'h000a_0096
`define DFVP_RST_RATED      32'h0064_0064

// Timing: one time step of the sequencer
`define DFVP_TICK_MS        100
`define DFVP_CLK_KHZ        100000
`define DFVP_TICK_CYC       (`DFVP_TICK_MS * `DFVP_CLK_KHZ)
`define DFVP_MINUTE_MS      60000
`define DFVP_MINUTE_TICKS   (`DFVP_MINUTE_MS / `DFVP_TICK_MS)

// Scale of voltage figures: per mille of rated voltage
`define DFVP_FULL_PM        1000
`define DFVP_AUTO_GAIN_PM   100

`endif

// ===== bench/dfvp_motor.sv
`timescale 1ns/100ps
module dfvp_motor (
  input  wire         ref_clk,
  input  wire         rst_n,
  input  wire         gate_enable_q,
  input  wire         dc_inject_q,
  input  wire  [15:0] dc_current_q,
  input  wire  [15:0] load,
  input  wire  [15:0] supply,
  output logic [15:0] output_current,
  output logic [15:0] main_input_volt
);
  // Sensor lags one cycle; with the gate off only the injected DC current flows
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      output_current  <= 16'h0000;
      main_input_volt <= 16'h0000;
    end else begin
      output_current  <= gate_enable_q ? load :
                         (dc_inject_q ? dc_current_q : 16'h0000);
      main_input_volt <= supply;
    end
  end
endmodule // dfvp_motor

// ===== bench/dfvp_top_props.sv
`timescale 1ns/100ps
`include "dfvp_regs.vh"
module dfvp_chk (
  input wire        ref_clk,
  input wire        rst_n,
  input wire [7:0]  reg_addr,
  input wire [31:0] reg_wdata,
  input wire        reg_wr,
  input wire [15:0] main_input_volt,
  input wire [15:0] out_freq_q,
  input wire [15:0] volt_cmd_q,
  input wire [15:0] dc_current_q,
  input wire        dc_inject_q,
  input wire        gate_enable_q,
  input wire        motor_thermal_trip,
  input wire        multifunction_output_pin
);
  // Shadows of settings, since only the ports are visible here
  logic [15:0] max_q;
  logic [15:0] rated_q;
  logic        mo_q;
  logic [2:0]  clr_age_q;
  wire         ctrl_wr = reg_wr && reg_addr == `DFVP_REG_CTRL;
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      max_q     <= 16'(`DFVP_RST_FREQLIM);
      rated_q   <= 16'(`DFVP_RST_RATED);
      mo_q      <= 1'b0;
      clr_age_q <= 3'h7;
    end else begin
      if (reg_wr && reg_addr == `DFVP_REG_FREQLIM) max_q <= reg_wdata[15:0];
      if (reg_wr && reg_addr == `DFVP_REG_RATED) rated_q <= reg_wdata[15:0];
      if (ctrl_wr) mo_q <= reg_wdata[`DFVP_CTRL_MO_OL];
      if (ctrl_wr && reg_wdata[`DFVP_CTRL_TRIP_CLR]) clr_age_q <= 3'h0;
      else if (clr_age_q != 3'h7) clr_age_q <= clr_age_q + 3'h1;
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  sequence s_trip_fall;
    motor_thermal_trip ##1 !motor_thermal_trip;
  endsequence
  sequence s_supply_calm;
    $stable(main_input_volt) [*3];
  endsequence
  chk_dc_no_gate: assert property (dc_inject_q |-> !gate_enable_q)
    else $error("gate on during dc injection");
  chk_trip_cuts_gate: assert property (
    motor_thermal_trip [*3] |-> !gate_enable_q)
    else $error("gate on while tripped");
  chk_volt_capped: assert property (
    s_supply_calm |-> volt_cmd_q <= main_input_volt)
    else $error("voltage above supply");
  chk_dc_idle_zero: assert property (
    !dc_inject_q [*2] |-> dc_current_q == 16'h0000)
    else $error("dc current without injection");
  chk_dc_rated_cap: assert property (dc_current_q <= rated_q)
    else $error("dc current above rated");
  chk_max_freq: assert property (out_freq_q <= max_q)
    else $error("frequency above maximum");
  chk_alarm_gated: assert property (
    !mo_q [*3] |-> !multifunction_output_pin)
    else $error("alarm on unassigned output");
  chk_trip_clear: assert property (s_trip_fall |-> clr_age_q < 3'h5)
    else $error("trip dropped without clear");
endmodule // dfvp_chk
bind dfvp_top dfvp_chk u_chk (.ref_clk, .rst_n, .reg_addr, .reg_wdata,
  .reg_wr, .main_input_volt, .out_freq_q, .volt_cmd_q, .dc_current_q,
  .dc_inject_q, .gate_enable_q, .motor_thermal_trip,
  .multifunction_output_pin);

// ===== bench/testbench.sv
`timescale 1ns/100ps
`include "dfvp_regs.vh"
module testbench;
  localparam int T = 50;
  logic        ref_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [7:0]  reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic        run_cmd = 1'b0;
  logic        dir_reverse = 1'b0;
  logic        dc_brake_input = 1'b0;
  logic [15:0] load = 16'h0000;
  logic [15:0] supply = 16'h04b0;
  logic [15:0] hl = 16'h1770;
  logic [15:0] lf = 16'h9173;
  logic [15:0] f, v, va;
  logic [31:0] rd;
  wire  [31:0] reg_rdata;
  wire  [15:0] output_current, main_input_volt, out_freq_q, volt_cmd_q;
  wire  [15:0] dc_current_q;
  wire         dc_inject_q, gate_enable_q, motor_thermal_trip, alarm;
  int          error_cnt = 0;
  int          tests_run = 0;
  int          i, n;
  always #5 ref_clk = ~ref_clk;
  // Short tick keeps the thermal minute inside the run
  dfvp_top #(.TICK_CYC(T)) DUT (.ref_clk, .rst_n, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .run_cmd, .dir_reverse, .dc_brake_input,
    .output_current, .main_input_volt, .out_freq_q, .volt_cmd_q,
    .dc_current_q, .dc_inject_q, .gate_enable_q, .motor_thermal_trip,
    .multifunction_output_pin(alarm));
  dfvp_motor u_motor (.ref_clk, .rst_n, .gate_enable_q, .dc_inject_q,
    .dc_current_q, .load, .supply, .output_current, .main_input_volt);
  function automatic logic [15:0] nxt(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function automatic logic [15:0] dcx(input logic [31:0] l, r);
    return 16'((l * r) / 32'h0000_03e8);
  endfunction
  task automatic summarize();
    if (error_cnt == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tk(input int k);
    repeat (k * T) @(posedge ref_clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge ref_clk);
    reg_wr    <= 1'b0;
  endtask
  task automatic rdr(input logic [7:0] a);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge ref_clk);
    reg_rd   <= 1'b0;
    @(posedge ref_clk);
    rd = reg_rdata;
  endtask
  task automatic go(input logic [15:0] r, e, input logic d);
    wr(`DFVP_REG_HIGHREF, {hl, r});
    dir_reverse <= d;
    run_cmd     <= 1'b1;
    for (n = 0; n < 40 * T && out_freq_q !== e; n++) @(posedge ref_clk);
    tk(4);
    v = volt_cmd_q;
  endtask
  task automatic gv(input logic [15:0] r, exp);
    go(r, r, 1'b0);
    chk(v, exp);
  endtask
  task automatic stop();
    @(posedge ref_clk);
    run_cmd <= 1'b0;
    for (n = 0; n < 40 * T && (gate_enable_q | dc_inject_q) !== 1'b0; n++)
      @(posedge ref_clk);
    tk(4);
    chk(dc_inject_q, 1'b0);
  endtask
  initial begin
    #900000;
    error_cnt++;
    summarize();
  end
  initial begin
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    rdr(`DFVP_REG_FREQLIM);
    chk(rd, `DFVP_RST_FREQLIM);
    rdr(8'h80);
    chk(rd, 32'h0);
    wr(`DFVP_REG_FREQLIM, 32'h2000_1000);
    rdr(`DFVP_REG_FREQLIM);
    chk(rd, 32'h1000_1000);
    wr(`DFVP_REG_CTRL, 32'h0);
    wr(`DFVP_REG_RATED, 32'h0400_0064);
    wr(`DFVP_REG_BOOST, 32'h0);
    wr(`DFVP_REG_STARTBRK, 32'h0003_0050);
    run_cmd <= 1'b1;
    for (n = 0; n < 20 && dc_inject_q !== 1'b1; n++) @(posedge ref_clk);
    chk(gate_enable_q, 1'b0);
    chk(dc_current_q, dcx(32'h50, 32'h64));
    for (n = 0; n < 5 * T && dc_inject_q === 1'b1; n++) @(posedge ref_clk);
    chk(n >= 2 * T && n <= 3 * T + 2, 1'b1);
    for (i = 0; i < 3; i++) begin
      lf = nxt(lf);
      f = 16'h0800 + (lf & 16'h0fff);
      go(f, (f > 16'h1000) ? 16'h1000 : f, 1'b0);
      chk(out_freq_q, (f > 16'h1000) ? 16'h1000 : f);
    end
    gv(16'h1000, 16'h03e8);
    gv(16'h0800, 16'h01f4);
    wr(`DFVP_REG_CTRL, 32'h0000_0008);
    gv(16'h0800, 16'h00fa);
    wr(`DFVP_REG_CTRL, 32'h0);
    wr(`DFVP_REG_VOLTADJ, 32'h0000_006e);
    supply <= 16'h0384;
    gv(16'h1000, 16'h0384);
    supply <= 16'h04b0;
    gv(16'h1000, 16'h044c);
    wr(`DFVP_REG_VOLTADJ, 32'h0014_0064);
    gv(16'h1000, 16'h0320);
    wr(`DFVP_REG_VOLTADJ, 32'h0000_0064);
    gv(16'h1000, 16'h03e8);
    wr(`DFVP_REG_CTRL, 32'h0000_0002);
    hl = 16'h0c00;
    go(16'h1000, 16'h0c00, 1'b0);
    chk(out_freq_q, 16'h0c00);
    wr(`DFVP_REG_STARTLOW, 32'h0600_0032);
    go(16'h0400, 16'h0600, 1'b0);
    chk(out_freq_q, 16'h0600);
    hl = 16'h1770;
    wr(`DFVP_REG_CTRL, 32'h0);
    stop();
    for (i = 0; i < 2; i++) begin
      wr(`DFVP_REG_STARTBRK, i ? 32'h0000_0050 : 32'h0003_0000);
      run_cmd <= 1'b1;
      tk(1);
      chk(dc_inject_q, 1'b0);
      stop();
    end
    wr(`DFVP_REG_HIGHREF, 32'h1770_0020);
    run_cmd <= 1'b1;
    tk(5);
    chk(volt_cmd_q, 16'h0000);
    stop();
    dc_brake_input <= 1'b1;
    tk(1);
    chk(dc_inject_q, 1'b1);
    chk(dc_current_q, dcx(32'h50, 32'h64));
    dc_brake_input <= 1'b0;
    tk(1);
    wr(`DFVP_REG_BOOST, 32'h0000_0064);
    go(16'h0400, 16'h0400, 1'b0);
    va = v;
    stop();
    go(16'h0400, 16'h0400, 1'b1);
    chk(va > v, 1'b1);
    stop();
    wr(`DFVP_REG_CTRL, 32'h0000_0004);
    load <= 16'h00c8;
    go(16'h0400, 16'h0400, 1'b0);
    chk(v > va, 1'b1);
    wr(`DFVP_REG_CTRL, 32'h0000_0204);
    tk(4);
    chk(volt_cmd_q, va);
    load <= 16'h0000;
    stop();
    for (i = 0; i < 4; i++)
      wr(`DFVP_REG_USER1 + 8'(4 * i),
         {16'(16'h00c8 * (i + 1)), 16'(16'h0400 * (i + 1))});
    wr(`DFVP_REG_CTRL, 32'h0000_0010);
    gv(16'h0800, 16'h0190);
    stop();
    go(16'h0800, 16'h0800, 1'b1);
    chk(v, 16'h0190);
    stop();
    wr(`DFVP_REG_CTRL, 32'h0000_0001);
    wr(`DFVP_REG_STOPFREQ, 32'h0002_01f4);
    wr(`DFVP_REG_STOPBRK, 32'h0002_0032);
    go(16'h1000, 16'h1000, 1'b0);
    run_cmd <= 1'b0;
    for (n = 0; n < 40 * T && gate_enable_q !== 1'b0; n++) @(posedge ref_clk);
    for (n = 0; n < 4 * T && dc_inject_q !== 1'b1; n++) @(posedge ref_clk);
    chk(n >= T && n <= 2 * T + 3, 1'b1);
    chk(dc_current_q, dcx(32'h32, 32'h64));
    tk(6);
    wr(`DFVP_REG_CTRL, 32'h0000_0080);
    wr(`DFVP_REG_WARN, 32'h0002_0096);
    go(16'h0800, 16'h0800, 1'b0);
    load <= 16'h00c8;
    for (n = 0; n < 4 * T && alarm !== 1'b1; n++) @(posedge ref_clk);
    chk(n >= T && n <= 3 * T + 4, 1'b1);
    load <= 16'h0032;
    tk(1);
    chk(alarm & gate_enable_q, 1'b1);
    for (n = 0; n < 4 * T && alarm !== 1'b0; n++) @(posedge ref_clk);
    chk(n < 4 * T, 1'b1);
    stop();
    // Forced cooling keeps the trip time free of speed derating
    wr(`DFVP_REG_CTRL, 32'h0000_0060);
    go(16'h0800, 16'h0800, 1'b0);
    load <= 16'h0096;
    for (n = 0; n < 800 * T && motor_thermal_trip !== 1'b1; n++)
      @(posedge ref_clk);
    chk(n >= 300 * T && n <= 720 * T, 1'b1);
    tk(1);
    chk(gate_enable_q, 1'b0);
    run_cmd <= 1'b0;
    load <= 16'h0000;
    // Heat is still high, so protection goes off before the clear
    wr(`DFVP_REG_CTRL, 32'h0000_0000);
    wr(`DFVP_REG_CTRL, 32'h0000_0100);
    tk(1);
    chk(motor_thermal_trip, 1'b0);
    summarize();
  end
endmodule // testbench
